// File: rtl/lamp_timing_pkg.sv
// Constants, types and step tables for the lamp switch timing block
package lamp_timing_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_MHZ         = 200;
  localparam int          CYCLES_PER_US   = CLK_MHZ;
  localparam int          MS_DEFAULT      = 1000 * CYCLES_PER_US;
  localparam int          PWM_STEPS       = 256;
  localparam int          PWM_MAX_HZ      = 1000;
  localparam int          PWM_DEFAULT_HZ  = 120;
  localparam logic [15:0] STEP_MIN_CYC    = 16'((CLK_MHZ * 1000000) / (PWM_MAX_HZ * PWM_STEPS) + 1);
  localparam logic [15:0] STEP_DEF_CYC    = 16'((CLK_MHZ * 1000000) / (PWM_DEFAULT_HZ * PWM_STEPS));
  localparam real         FAIL_LOW_KHZ    = 2.0;
  localparam real         FAIL_HIGH_KHZ   = 200.0;
  localparam logic [9:0]  FAIL_LOW_US     = 10'(1000.0 / FAIL_LOW_KHZ);
  localparam logic [11:0] FAIL_HIGH_CYC   = 12'(CLK_MHZ * 1000.0 / FAIL_HIGH_KHZ);
  localparam logic [8:0]  CAL_MIN_US      = 9'd20;
  localparam logic [8:0]  CAL_MAX_US      = 9'd200;
  localparam logic [8:0]  TOGGLE_MS       = 9'd250;
  localparam logic [2:0]  LAST_STEP       = 3'd6;
  localparam logic [7:0]  DUTY_FULL       = 8'hFF;
  localparam logic [7:0]  DUTY_OFF        = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RATE_MEDIUM, RATE_FAST, RATE_SLOW} rate_e;

  typedef struct packed {
    logic       lamp_28w;
    logic [1:0] cooling_rate_field;
  } cooling_cfg_s;

  typedef struct packed {
    logic       enable;
    logic       clock_source_select;
    logic [7:0] duty;
  } pwm_cfg_s;

  // Step length in ms, index 1..6
  function automatic logic [10:0] step_ms(input logic w28, input rate_e r, input logic [2:0] i);
    logic [10:0] t;
    t = 11'd0;
    unique case (i)
      3'd1: t = w28 ? 11'd417 : 11'd347;
      3'd2: t = w28 ? 11'd224 : 11'd181;
      3'd3: t = w28 ? 11'd255 : 11'd200;
      3'd4: t = w28 ? 11'd298 : 11'd226;
      3'd5: t = w28 ? 11'd359 : 11'd259;
      default: t = w28 ? 11'd449 : 11'd302;
    endcase
    if (r == RATE_FAST) begin
      unique case (i)
        3'd1: t = w28 ? 11'd209 : 11'd173;
        3'd2: t = w28 ? 11'd112 : 11'd90;
        3'd3: t = w28 ? 11'd127 : 11'd100;
        3'd4: t = w28 ? 11'd145 : 11'd113;
        3'd5: t = w28 ? 11'd180 : 11'd129;
        default: t = w28 ? 11'd324 : 11'd151;
      endcase
    end else if (r == RATE_SLOW) begin
      unique case (i)
        3'd1: t = w28 ? 11'd834 : 11'd694;
        3'd2: t = w28 ? 11'd448 : 11'd362;
        3'd3: t = w28 ? 11'd510 : 11'd400;
        3'd4: t = w28 ? 11'd596 : 11'd452;
        3'd5: t = w28 ? 11'd717 : 11'd518;
        default: t = w28 ? 11'd898 : 11'd604;
      endcase
    end
    return t;
  endfunction : step_ms

endpackage : lamp_timing_pkg

// File: rtl/lamp_switch_timing_control.sv
// Cooling sequencer, PWM timing, clock check, calibration and input timeout
`timescale 1ns/1ps
`default_nettype none
module lamp_switch_timing_control
  import lamp_timing_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_DEFAULT
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Cooling control
  input  wire logic         cooling_restart,
  input  wire cooling_cfg_s cooling_cfg,
  output logic [2:0]        cooling_step,
  output logic              cooling_step_done,
  output logic              cooling_active,
  // PWM control
  input  wire pwm_cfg_s     pwm_cfg,
  input  wire logic [3:0]   direct_input,
  input  wire logic         chip_select_n,
  output logic              pwm_out,
  // Status
  output logic              clock_fail,
  output logic              calibrated,
  output logic              cal_too_short,
  output logic              cal_too_long,
  output logic              input_timeout
);

  // ------------------------------------------------------------
  // Time bases
  // ------------------------------------------------------------
  logic [7:0]  us_cnt;
  logic [31:0] ms_cnt;
  logic        us_tick;
  logic        ms_tick;

  assign us_tick = (us_cnt == 8'(CYCLES_PER_US - 1));
  assign ms_tick = (ms_cnt == 32'(CYCLES_PER_MS - 1));

  always_ff @(posedge ref_clk) begin
    us_cnt <= (sys_rst || us_tick) ? 8'h00 : us_cnt + 8'h01;
    ms_cnt <= (sys_rst || ms_tick) ? 32'h0 : ms_cnt + 32'h1;
  end

  // ------------------------------------------------------------
  // Bulb cooling sequencer
  // ------------------------------------------------------------
  rate_e       rate;
  logic [10:0] step_len;
  logic [10:0] step_ms_cnt;
  logic        step_expire;

  assign rate = (cooling_cfg.cooling_rate_field == 2'b01) ? RATE_FAST :
                (cooling_cfg.cooling_rate_field == 2'b10) ? RATE_SLOW :
                RATE_MEDIUM;
  assign step_len    = step_ms(cooling_cfg.lamp_28w, rate, cooling_step);
  assign step_expire = cooling_active && ms_tick && (step_ms_cnt >= step_len - 11'd1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cooling_step      <= 3'd1;
      cooling_active    <= 1'b0;
      step_ms_cnt       <= 11'h000;
      cooling_step_done <= 1'b0;
    end else if (cooling_restart) begin
      cooling_step      <= 3'd1;
      cooling_active    <= 1'b1;
      step_ms_cnt       <= 11'h000;
      cooling_step_done <= 1'b0;
    end else begin
      cooling_step_done <= step_expire;
      if (step_expire) begin
        step_ms_cnt <= 11'h000;
        if (cooling_step == LAST_STEP) begin
          cooling_active <= 1'b0;
        end else begin
          cooling_step <= cooling_step + 3'd1;
        end
      end else if (cooling_active && ms_tick) begin
        step_ms_cnt <= step_ms_cnt + 11'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // External clock edge and failure detector
  // ------------------------------------------------------------
  logic        in0_prev;
  logic        in0_rise;
  logic        detect_on;
  logic        edge_seen;
  logic        edge_short;
  logic [11:0] edge_cyc;
  logic [9:0]  edge_us;

  assign in0_rise   = direct_input[0] && !in0_prev;
  assign detect_on  = pwm_cfg.enable && !pwm_cfg.clock_source_select;
  assign edge_short = edge_seen && (edge_cyc < FAIL_HIGH_CYC - 12'h001);

  // Pin history kept while disarmed, so arming gives no false edge
  always_ff @(posedge ref_clk) begin
    in0_prev <= direct_input[0];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !detect_on) begin
      edge_seen  <= 1'b0;
      edge_cyc   <= 12'h000;
      edge_us    <= 10'h000;
      clock_fail <= 1'b0;
    end else begin
      if (in0_rise) begin
        // First edge after arming only starts the spacing count
        edge_seen  <= 1'b1;
        edge_cyc   <= 12'h000;
        edge_us    <= 10'h000;
        clock_fail <= edge_short || (edge_us == FAIL_LOW_US);
      end else begin
        if (edge_cyc != 12'hFFF) begin
          edge_cyc <= edge_cyc + 12'h001;
        end
        if (us_tick && edge_us != FAIL_LOW_US) begin
          edge_us <= edge_us + 10'h001;
        end
        if (edge_us == FAIL_LOW_US) begin
          clock_fail <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Chip select calibration pulse
  // ------------------------------------------------------------
  logic        cs_prev;
  logic [8:0]  cs_low_us;
  logic        cs_end;
  logic [15:0] cal_step_cyc;

  assign cs_end = chip_select_n && !cs_prev;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_prev       <= 1'b1;
      cs_low_us     <= 9'h000;
      calibrated    <= 1'b0;
      cal_step_cyc  <= STEP_DEF_CYC;
      cal_too_short <= 1'b0;
      cal_too_long  <= 1'b0;
    end else begin
      cs_prev       <= chip_select_n;
      cal_too_short <= cs_end && (cs_low_us < CAL_MIN_US);
      cal_too_long  <= cs_end && (cs_low_us > CAL_MAX_US);
      if (!chip_select_n) begin
        if (us_tick && cs_low_us <= CAL_MAX_US) begin
          cs_low_us <= cs_low_us + 9'h001;
        end
      end else begin
        cs_low_us <= 9'h000;
      end
      if (cs_end && cs_low_us >= CAL_MIN_US && cs_low_us <= CAL_MAX_US) begin
        calibrated   <= 1'b1;
        cal_step_cyc <= 16'(cs_low_us * CYCLES_PER_US);
      end
    end
  end

  // ------------------------------------------------------------
  // PWM generator
  // ------------------------------------------------------------
  logic [15:0] osc_cnt;
  logic [15:0] osc_len;
  logic        osc_tick;
  logic        pwm_step;
  logic [7:0]  pwm_phase;
  logic        next_pwm;

  // Floor keeps the internal rate at or below the frequency limit
  assign osc_len  = (cal_step_cyc < STEP_MIN_CYC) ? STEP_MIN_CYC : cal_step_cyc;
  assign osc_tick = (osc_cnt >= osc_len - 16'h0001);
  assign pwm_step = pwm_cfg.clock_source_select ? osc_tick : in0_rise;
  assign next_pwm = !pwm_cfg.enable           ? direct_input[0] :
                    (pwm_cfg.duty == DUTY_FULL) ? 1'b1 :
                    (pwm_cfg.duty == DUTY_OFF)  ? 1'b0 :
                    (pwm_phase < pwm_cfg.duty);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !pwm_cfg.enable) begin
      osc_cnt   <= 16'h0000;
      pwm_phase <= 8'h00;
    end else begin
      osc_cnt <= osc_tick ? 16'h0000 : osc_cnt + 16'h0001;
      if (pwm_step) begin
        pwm_phase <= pwm_phase + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    pwm_out <= sys_rst ? 1'b0 : next_pwm;
  end

  // ------------------------------------------------------------
  // Direct input toggle timeout
  // ------------------------------------------------------------
  logic [3:0] din_prev;
  logic [8:0] idle_ms;
  logic       din_toggle;

  assign din_toggle = (din_prev != direct_input);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      din_prev      <= 4'h0;
      idle_ms       <= 9'h000;
      input_timeout <= 1'b0;
    end else begin
      din_prev <= direct_input;
      if (din_toggle) begin
        idle_ms       <= 9'h000;
        input_timeout <= 1'b0;
      end else if (ms_tick && idle_ms != TOGGLE_MS) begin
        idle_ms <= idle_ms + 9'h001;
      end else if (idle_ms == TOGGLE_MS) begin
        input_timeout <= 1'b1;
      end
    end
  end

endmodule : lamp_switch_timing_control
`default_nettype wire

// File: sim/lamp_timing_assertions.sv
// Port relation checks for the lamp timing block
`timescale 1ns/1ps
`default_nettype none
module lamp_timing_assertions
  import lamp_timing_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       cooling_restart,
  input wire logic [2:0] cooling_step,
  input wire logic       cooling_step_done,
  input wire logic       cooling_active,
  input wire pwm_cfg_s   pwm_cfg,
  input wire logic [3:0] direct_input,
  input wire logic       chip_select_n,
  input wire logic       pwm_out,
  input wire logic       clock_fail,
  input wire logic       cal_too_short,
  input wire logic       cal_too_long,
  input wire logic       input_timeout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic ext_sel = pwm_cfg.enable && !pwm_cfg.clock_source_select;
  property p_restart; cooling_restart |=> cooling_active && cooling_step == 3'h1; endproperty
  a_restart: assert property (p_restart) else $error("restart not at step one");
  property p_advance; cooling_step != $past(cooling_step) && !$past(cooling_restart)
    |-> cooling_step_done && cooling_step == $past(cooling_step) + 3'h1; endproperty
  a_advance: assert property (p_advance) else $error("step moved wrongly");
  property p_range; cooling_step >= 3'h1 && cooling_step <= LAST_STEP; endproperty
  a_range: assert property (p_range) else $error("step index out of range");
  property p_pass; !pwm_cfg.enable && !$past(pwm_cfg.enable) && !$past(sys_rst)
    |-> pwm_out == $past(direct_input[0]); endproperty
  a_pass: assert property (p_pass) else $error("direct path not followed");
  property p_full; (pwm_cfg.enable && pwm_cfg.duty == DUTY_FULL) [*3] |-> pwm_out; endproperty
  a_full: assert property (p_full) else $error("full duty not on");
  property p_off; (pwm_cfg.enable && pwm_cfg.duty == DUTY_OFF) [*3] |-> !pwm_out; endproperty
  a_off: assert property (p_off) else $error("zero duty not off");
  property p_fail_src; $rose(clock_fail) |-> $past(ext_sel); endproperty
  a_fail_src: assert property (p_fail_src) else $error("fail raised while unarmed");
  property p_fail_off; (!ext_sel) [*2] |-> !clock_fail; endproperty
  a_fail_off: assert property (p_fail_off) else $error("fail kept while unarmed");
  property p_short; cal_too_short |-> $past(chip_select_n) && !cal_too_long; endproperty
  a_short: assert property (p_short) else $error("short flag misplaced");
  property p_long; cal_too_long |=> !cal_too_long; endproperty
  a_long: assert property (p_long) else $error("long flag not a pulse");
  property p_tmo; input_timeout && direct_input != $past(direct_input) |-> ##[1:2] !input_timeout;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not cleared");
endmodule : lamp_timing_assertions
bind lamp_switch_timing_control lamp_timing_assertions u_lamp_timing_assertions (
  .ref_clk           (ref_clk),
  .sys_rst           (sys_rst),
  .cooling_restart   (cooling_restart),
  .cooling_step      (cooling_step),
  .cooling_step_done (cooling_step_done),
  .cooling_active    (cooling_active),
  .pwm_cfg           (pwm_cfg),
  .direct_input      (direct_input),
  .chip_select_n     (chip_select_n),
  .pwm_out           (pwm_out),
  .clock_fail        (clock_fail),
  .cal_too_short     (cal_too_short),
  .cal_too_long      (cal_too_long),
  .input_timeout     (input_timeout)
);
`default_nettype wire

// File: sim/host_pwm_clock.sv
// Host model driving the external PWM clock on direct input zero
`timescale 1ns/1ps
`default_nettype none
module host_pwm_clock (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic [15:0] half_cyc,
  output wire logic        in0
);
  logic        level = 1'b0;
  logic [15:0] cnt   = 16'h0000;
  assign in0 = level;
  // Clock stands still while not running
  always @(negedge ref_clk) begin
    if (run && cnt + 16'h0001 >= half_cyc) begin
      cnt   <= 16'h0000;
      level <= ~level;
    end else if (run) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : host_pwm_clock
`default_nettype wire

// File: sim/lamp_switch_timing_control_tb.sv
// Self-checking bench for the lamp timing block
`timescale 1ns/1ps
`default_nettype none
module lamp_switch_timing_control_tb import lamp_timing_pkg::*;;
  localparam int CPM = 20;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         cooling_restart = 1'b0;
  cooling_cfg_s cooling_cfg = 3'h0;
  pwm_cfg_s     pwm_cfg = 10'h000;
  logic [2:0]   di_hi = 3'h0;
  logic         chip_select_n = 1'b1;
  logic         run = 1'b0;
  logic [15:0]  half_cyc = 16'h0002;
  wire logic    in0;
  wire logic [3:0] direct_input = {di_hi, in0};
  wire logic [2:0] cooling_step;
  wire logic    cooling_step_done, cooling_active, pwm_out, clock_fail, calibrated;
  wire logic    cal_too_short, cal_too_long, input_timeout;
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h0C2A;
  int cyc = 0;
  int n;
  int e;
  int exp_q[$];
  int fast[6] = '{173, 90, 100, 113, 129, 151};
  int ones[4] = '{347, 347, 694, 417};
  cooling_cfg_s cfgs[4] = '{3'h0, 3'h3, 3'h2, 3'h4};
  always #2.5 ref_clk = ~ref_clk;
  lamp_switch_timing_control #(.CYCLES_PER_MS(CPM)) u_lamp_switch_timing_control (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .cooling_restart   (cooling_restart),
    .cooling_cfg       (cooling_cfg),
    .cooling_step      (cooling_step),
    .cooling_step_done (cooling_step_done),
    .cooling_active    (cooling_active),
    .pwm_cfg           (pwm_cfg),
    .direct_input      (direct_input),
    .chip_select_n     (chip_select_n),
    .pwm_out           (pwm_out),
    .clock_fail        (clock_fail),
    .calibrated        (calibrated),
    .cal_too_short     (cal_too_short),
    .cal_too_long      (cal_too_long),
    .input_timeout     (input_timeout)
  );
  host_pwm_clock u_host_pwm_clock (
    .ref_clk  (ref_clk),
    .run      (run),
    .half_cyc (half_cyc),
    .in0      (in0)
  );
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] g);
    cmp_count++;
    if (ex !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, ex, g);
    end
  endtask : check
  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic ticks(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : ticks
  task automatic pulse_restart;
    cooling_restart = 1'b1;
    @(negedge ref_clk);
    cooling_restart = 1'b0;
  endtask : pulse_restart
  task automatic cal_pulse(input int us, input logic es, input logic el);
    logic sh;
    logic lg;
    chip_select_n = 1'b0;
    ticks(us * CYCLES_PER_US);
    chip_select_n = 1'b1;
    sh = 1'b0;
    lg = 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      sh = sh | cal_too_short;
      lg = lg | cal_too_long;
    end
    check("cal_too_short", es, sh);
    check("cal_too_long", el, lg);
    check("calibrated", !(es || el), calibrated);
  endtask : cal_pulse
  // Step length monitor, tolerant of the short first ms
  always @(posedge ref_clk) begin
    cyc <= (cooling_restart || cooling_step_done) ? 0 : cyc + 1;
    if (cooling_step_done === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front() * CPM;
      cmp_count++;
      if (cyc + CPM < e || cyc > e + CPM) begin
        error_cnt++;
        $display("unexpected step length: expected %0d seen %0d", e, cyc);
      end
    end
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    ticks(10);
    sys_rst = 1'b0;
    check("cooling_step", 3'h1, cooling_step);
    fork
      begin
        cooling_cfg = 3'h1;
        foreach (fast[i]) exp_q.push_back(fast[i]);
        pulse_restart();
        repeat (6) @(posedge cooling_step_done);
        ticks(200 * CPM);
        check("cooling_step", LAST_STEP, cooling_step);
        check("cooling_active", 1'b0, cooling_active);
        for (int i = 0; i < 4; i++) begin
          cooling_cfg = cfgs[i];
          exp_q.push_back(ones[i]);
          pulse_restart();
          @(posedge cooling_step_done);
          @(negedge ref_clk);
        end
      end
      begin
        cal_pulse(10, 1'b1, 1'b0);
        cal_pulse(210, 1'b0, 1'b1);
        cal_pulse(100, 1'b0, 1'b0);
      end
      begin
        pwm_cfg = {1'b1, 1'b0, DUTY_OFF};
        run = 1'b1;
        ticks(40);
        check("clock_fail", 1'b1, clock_fail);
        check("pwm_out", 1'b0, pwm_out);
        pwm_cfg.duty = 8'h40;
        ticks(2);
        n = 0;
        repeat (1024) begin
          @(negedge ref_clk);
          if (pwm_out === 1'b1) n++;
        end
        check("pwm high cycles", 1'b1, n >= 32'h40 * 4 - 4 && n <= 32'h40 * 4 + 4);
        half_cyc = 16'h07D0;
        ticks(9000);
        check("clock_fail", 1'b0, clock_fail);
        half_cyc = 16'h0002;
        pwm_cfg = {1'b1, 1'b1, DUTY_FULL};
        ticks(40);
        check("clock_fail", 1'b0, clock_fail);
        check("pwm_out", 1'b1, pwm_out);
        pwm_cfg.enable = 1'b0;
        ticks(40);
        check("clock_fail", 1'b0, clock_fail);
        pwm_cfg.enable = 1'b1;
        repeat (64) begin
          pwm_cfg.duty = 8'($random(seed));
          di_hi = 3'($random(seed));
          ticks(8);
        end
        run = 1'b0;
        n = 0;
        while (input_timeout !== 1'b1 && n < 300 * CPM) begin
          @(negedge ref_clk);
          n++;
        end
        check("timeout window", 1'b1, n >= 249 * CPM && n <= 251 * CPM);
        di_hi = ~di_hi;
        ticks(3);
        check("input_timeout", 1'b0, input_timeout);
      end
    join
    print_verdict();
  end
endmodule : lamp_switch_timing_control_tb
`default_nettype wire
